// ===== dpio_regs.vh
// register offsets, reset values and line-mode codes for the dual pin port
`ifndef DPIO_REGS_VH
`define DPIO_REGS_VH
// ----------------------------------------
// register offsets (data-space index)
// ----------------------------------------
`define DPIO_OFS_A_VALUE 3'h0
`define DPIO_OFS_B_VALUE 3'h1
`define DPIO_OFS_A_DIR 3'h2
`define DPIO_OFS_B_DIR 3'h3
`define DPIO_OFS_A_OPT 3'h4
`define DPIO_OFS_B_OPT 3'h5
`define DPIO_OFS_EDGE 3'h6
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define DPIO_RST_BYTE 8'h00
`define DPIO_RST_EDGE 2'h0
`define DPIO_EDGE_A_BIT 0
`define DPIO_EDGE_B_BIT 1
// ----------------------------------------
// line mode codes {direction, option, value}
// ----------------------------------------
`define DPIO_MODE_PULLUP 3'h0
`define DPIO_MODE_HIZ 3'h1
`define DPIO_MODE_IRQ 3'h2
`define DPIO_MODE_ANALOG 3'h3
// ----------------------------------------
// line ranges
// ----------------------------------------
`define DPIO_ANALOG_B_LINES 4
`define DPIO_HICUR_FIRST 4
`define DPIO_SERIAL_OUT_LINE 7
`endif

// ===== dpio_line.v
// one pin line: mode decode, pin drive and interrupt edge detection
`timescale 1ns/100ps
module dpio_line #(
  parameter HAS_ANALOG = 1,
  parameter HAS_HICUR = 0,
  parameter HAS_SERIAL = 0
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // configuration bits
  input wire dir_bit,
  input wire opt_bit,
  input wire val_bit,
  input wire rise_sel,
  input wire serial_out,
  // pin
  input wire pin_in,
  // decoded line controls
  output reg pin_out,
  output reg pin_oe,
  output reg pull_en,
  output reg analog_en,
  output reg hicur_en,
  output reg irq_en,
  output reg edge_hit
);
`include "dpio_regs.vh"
  reg sync1_q;
  reg sync2_q;
  reg last_q;
  wire [2:0] code;
  assign code = {dir_bit, opt_bit, val_bit};
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  always @* begin
    pull_en = 1'b0;
    analog_en = 1'b0;
    irq_en = 1'b0;
    pin_out = 1'b0;
    pin_oe = 1'b0;
    hicur_en = 1'b0;
    if (dir_bit) begin // RULE18
      if (opt_bit) begin // RULE16
        pin_out = val_bit;
        pin_oe = 1'b1;
      end else begin
        // open drain: drive only a low; line 7 of port b carries the serial data
        if (HAS_SERIAL != 0) begin // RULE19
          pin_oe = ~serial_out;
        end else begin
          pin_oe = ~val_bit;
        end
      end
      hicur_en = (HAS_HICUR != 0); // RULE16
    end else begin
      case (code) // RULE10 RULE17 RULE4
        `DPIO_MODE_PULLUP: begin
          pull_en = 1'b1;
        end
        `DPIO_MODE_HIZ: begin
          pull_en = 1'b0;
        end
        `DPIO_MODE_IRQ: begin
          pull_en = 1'b1;
          irq_en = 1'b1;
        end
        `DPIO_MODE_ANALOG: begin
          // lines without a converter input fall back to plain high impedance
          analog_en = (HAS_ANALOG != 0); // RULE13
        end
        default: begin
          pull_en = 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // start at the pull-up idle level, so leaving reset shows no false rising edge
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      sync1_q <= pin_in; // RULE20
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end
  // edge hits only count while the line is in interrupt mode
  always @* begin
    edge_hit = irq_en & (rise_sel ? (sync2_q & ~last_q) : (~sync2_q & last_q)); // RULE12
  end
endmodule // dpio_line

// ===== dpio_top.v
// dual 8-line pin port with data, direction and option registers
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: sixteen lines, each software-set as input or output with an option
// RULE2: two ports of three registers; bit n steers line n
// RULE3: value read gives input pin levels; write sets output levels
// RULE4: on inputs the written value bit with option bit picks input kind
// RULE5: input value reads sample pins; writes go to latch
// RULE6: per-port direction register selects input or output per line
// RULE7: per-port option register selects the line option in both modes
// RULE8: all port registers read and write like data memory
// RULE9: reset clears every register: inputs with pull-up, no interrupt
// RULE10: input pull-up set by option and value codes; otherwise high impedance
// RULE11: interrupt-mode inputs of both ports ORed into one vector-two request
// RULE12: per-port edge-option register picks rising or falling interrupt edge
// RULE13: port a lines 0-7 and port b lines 0-3 offer analog input
// RULE14: software selects at most one analog line at a time
// RULE15: port b lines 5-7 also carry serial interface signals
// RULE16: outputs push-pull or open drain; port b lines 4-7 high-current drain
// RULE17: an input mode without pull-up or interrupt exists
// RULE18: decode 000 pullup,001 hiz,010 pullup+irq,011 analog,10x drain,11x push-pull
// RULE19: port b line 7 open drain drives serial shift output, not latch
// RULE20: interrupt inputs synchronised before edge detect; request lasts one clock or more
module dpio_top (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // data-space register access
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // pins, port a in 7:0, port b in 15:8
  input wire [15:0] pin_in,
  output reg [15:0] pin_out,
  output reg [15:0] pin_oe,
  output reg [15:0] pin_pull_en,
  output reg [15:0] pin_hicur_en,
  // converter routing, port a lines 0-7 and port b lines 0-3
  output reg [11:0] analog_sel,
  // serial interface
  input wire serial_out,
  output reg serial_clk_in,
  output reg serial_data_in,
  // core interrupt request on vector two
  output reg pin_irq
);
`include "dpio_regs.vh"
  reg [7:0] a_value_q;
  reg [7:0] b_value_q;
  reg [7:0] a_dir_q;
  reg [7:0] b_dir_q;
  reg [7:0] a_opt_q;
  reg [7:0] b_opt_q;
  reg [1:0] edge_q;
  wire [15:0] value_w;
  wire [15:0] dir_w;
  wire [15:0] opt_w;
  wire [15:0] out_w;
  wire [15:0] oe_w;
  wire [15:0] pull_w;
  wire [15:0] ana_w;
  wire [15:0] hicur_w;
  wire [15:0] irqen_w;
  wire [15:0] hit_w;
  reg [7:0] rdata_d;
  assign value_w = {b_value_q, a_value_q};
  assign dir_w = {b_dir_q, a_dir_q};
  assign opt_w = {b_opt_q, a_opt_q};
  // pin value read: pins for inputs, latch for outputs
  function [7:0] value_view;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pins;
    begin
      value_view = (dir & latch) | (~dir & pins); // RULE5
    end
  endfunction
  // ----------------------------------------
  // per-line logic
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_line // RULE1
      dpio_line #(
        .HAS_ANALOG((i < 8) || (i < 8 + `DPIO_ANALOG_B_LINES)),
        .HAS_HICUR(i >= 8 + `DPIO_HICUR_FIRST),
        .HAS_SERIAL(i == 8 + `DPIO_SERIAL_OUT_LINE)
      ) u_line (
        .clock(clock),
        .rst_n(rst_n),
        .dir_bit(dir_w[i]), // RULE2
        .opt_bit(opt_w[i]),
        .val_bit(value_w[i]),
        .rise_sel(i < 8 ? edge_q[`DPIO_EDGE_A_BIT] : edge_q[`DPIO_EDGE_B_BIT]),
        .serial_out(serial_out),
        .pin_in(pin_in[i]),
        .pin_out(out_w[i]),
        .pin_oe(oe_w[i]),
        .pull_en(pull_w[i]),
        .analog_en(ana_w[i]),
        .hicur_en(hicur_w[i]),
        .irq_en(irqen_w[i]),
        .edge_hit(hit_w[i])
      );
    end
  endgenerate
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_value_q <= `DPIO_RST_BYTE; // RULE9
      b_value_q <= `DPIO_RST_BYTE;
      a_dir_q <= `DPIO_RST_BYTE;
      b_dir_q <= `DPIO_RST_BYTE;
      a_opt_q <= `DPIO_RST_BYTE;
      b_opt_q <= `DPIO_RST_BYTE;
      edge_q <= `DPIO_RST_EDGE;
    end else if (reg_wr) begin // RULE8
      case (reg_addr)
        `DPIO_OFS_A_VALUE: begin
          a_value_q <= reg_wdata; // RULE3
        end
        `DPIO_OFS_B_VALUE: begin
          b_value_q <= reg_wdata;
        end
        `DPIO_OFS_A_DIR: begin
          a_dir_q <= reg_wdata; // RULE6
        end
        `DPIO_OFS_B_DIR: begin
          b_dir_q <= reg_wdata;
        end
        `DPIO_OFS_A_OPT: begin
          a_opt_q <= reg_wdata; // RULE7
        end
        `DPIO_OFS_B_OPT: begin
          b_opt_q <= reg_wdata;
        end
        `DPIO_OFS_EDGE: begin
          edge_q <= reg_wdata[1:0]; // RULE12
        end
        default: begin
          edge_q <= edge_q;
        end
      endcase
    end
  end
  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @* begin
    case (reg_addr)
      `DPIO_OFS_A_VALUE: rdata_d = value_view(a_dir_q, a_value_q, pin_in[7:0]); // RULE3
      `DPIO_OFS_B_VALUE: rdata_d = value_view(b_dir_q, b_value_q, pin_in[15:8]);
      `DPIO_OFS_A_DIR: rdata_d = a_dir_q;
      `DPIO_OFS_B_DIR: rdata_d = b_dir_q;
      `DPIO_OFS_A_OPT: rdata_d = a_opt_q;
      `DPIO_OFS_B_OPT: rdata_d = b_opt_q;
      `DPIO_OFS_EDGE: rdata_d = {6'h00, edge_q};
      default: rdata_d = 8'h00;
    endcase
  end
  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
      pin_pull_en <= 16'hffff;
      pin_hicur_en <= 16'h0000;
      analog_sel <= 12'h000;
      serial_clk_in <= 1'b0;
      serial_data_in <= 1'b0;
      pin_irq <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      pin_out <= out_w;
      pin_oe <= oe_w;
      pin_pull_en <= pull_w; // RULE10
      pin_hicur_en <= hicur_w; // RULE16
      // no guard against several analog lines: keeping to one is software's job
      analog_sel <= ana_w[11:0]; // RULE13 RULE14
      serial_clk_in <= pin_in[13]; // RULE15
      serial_data_in <= pin_in[14];
      pin_irq <= |(hit_w & irqen_w); // RULE11 RULE20
    end
  end
endmodule // dpio_top

// ===== dpio_props.sv
// assertion checker for the dual pin port top
`timescale 1ns/100ps
module dpio_props (
  // clock, reset and registers
  input wire clock,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // pins
  input wire [15:0] pin_in,
  input wire [15:0] pin_oe,
  input wire [15:0] pin_pull_en,
  input wire [15:0] pin_hicur_en,
  input wire [11:0] analog_sel,
  input wire serial_clk_in,
  input wire pin_irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_reset_state: assert property ($rose(rst_n) |-> pin_oe == 16'h0000 && pin_pull_en == 16'hffff)
    else $error("reset state");
  a_input_quiet: assert property (reg_wr && reg_addr == 3'h2 && reg_wdata == 8'h00 |-> ##2 pin_oe[7:0] == 8'h00)
    else $error("input driven");
  a_analog_clean: assert property ((analog_sel & (pin_oe[11:0] | pin_pull_en[11:0])) == 12'h000)
    else $error("analog loaded");
  a_hicur_lines: assert property (pin_hicur_en[11:0] == 12'h000)
    else $error("high current line");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_serial_copy: assert property ($past(rst_n) |-> serial_clk_in == $past(pin_in[13]))
    else $error("serial clock copy");
  a_irq_pulse: assert property (pin_irq |=> !pin_irq)
    else $error("irq too long");
  a_irq_cause: assert property ($stable(pin_in) [*8] |=> !pin_irq)
    else $error("irq without edge");
  c_irq: cover property (pin_irq);
  c_analog: cover property (analog_sel != 12'h000);
  c_unmapped: cover property (reg_rd && reg_addr == 3'h7);
endmodule // dpio_props
bind dpio_top dpio_props i_dpio_props (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .pin_in, .pin_oe, .pin_pull_en, .pin_hicur_en, .analog_sel, .serial_clk_in, .pin_irq);

// ===== dpio_board.sv
// board model: outside drivers and pull resistors on the pins
`timescale 1ns/100ps
module dpio_board (
  // device side
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  input wire [15:0] pin_pull_en,
  // board side
  input wire [15:0] ext_val,
  input wire [15:0] ext_en,
  output wire [15:0] pin_lvl
);
  // a floating line without pull shows the inverse of the old board value, so no stale level hides
  wire [15:0] idle = pin_pull_en | ~ext_val;
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & idle)));
endmodule // dpio_board

// ===== dpio_top_tb.sv
// self-checking bench for the dual pin port
`timescale 1ns/100ps
`include "dpio_regs.vh"
module dpio_top_tb;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg serial_out = 1'b0;
  reg seen;
  reg [7:0] reg_wdata = 8'h00;
  reg [7:0] got;
  reg [15:0] ext_val = 16'h0000;
  reg [15:0] ext_en = 16'h0000;
  reg [2:0] p;
  reg [71:0] r;
  reg [71:0] rows [0:6];
  wire [15:0] pin_lvl, pin_out, pin_oe, pin_pull_en, pin_hicur_en;
  wire serial_clk_in, serial_data_in;
  wire [11:0] analog_sel;
  wire [7:0] reg_rdata;
  wire pin_irq;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer i;
  always #2 clock = ~clock;
  dpio_top i_dpio_top (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pin_in(pin_lvl),
    .pin_out, .pin_oe, .pin_pull_en, .pin_hicur_en, .analog_sel, .serial_out, .serial_clk_in, .serial_data_in,
    .pin_irq);
  dpio_board i_dpio_board (.pin_out, .pin_oe, .pin_pull_en, .ext_val, .ext_en, .pin_lvl);
  function [7:0] sel(input [15:0] v);
    sel = p[0] ? v[15:8] : v[7:0];
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
    end
  endtask
  task irq_step(input [15:0] v, input e);
    begin
      @(posedge clock);
      ext_en <= 16'hffff;
      ext_val <= v;
      seen = 1'b0;
      repeat (10) begin
        @(posedge clock);
        #1 if (pin_irq === 1'b1) seen = 1'b1;
      end
      chk(seen, e);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    // port, dir, option, value, board level, then oe, pull, analog, read value
    rows[0] = 72'h00_f0cc_aa53_d005_08a3;
    rows[1] = 72'h00_0000_ff3c_0000_003c;
    rows[2] = 72'h00_ffff_6900_ff00_0069;
    rows[3] = 72'h00_ff00_0f00_f000_000f;
    rows[4] = 72'h01_f0cc_aa53_d005_08a3;
    rows[5] = 72'h01_00ff_000f_00ff_000f;
    // code 011 on port b lines 4-7 has no converter input and must stay a plain input
    rows[6] = 72'h01_00f0_f0a5_000f_00a5;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    ext_en <= 16'hffff;
    for (i = 0; i < 7; i = i + 1) begin
      r = rows[i];
      p = r[66:64];
      @(posedge clock);
      ext_val <= {2{r[39:32]}};
      // value cleared first so no line of the port sits in analog mode while dir and option change
      wr(p, 8'h00);
      wr(`DPIO_OFS_A_DIR + p, r[63:56]);
      wr(`DPIO_OFS_A_OPT + p, r[55:48]);
      wr(p, r[47:40]);
      repeat (2) @(posedge clock);
      #1 chk(sel(pin_oe), r[31:24]);
      chk(sel(pin_out & pin_oe), r[63:56] & r[55:48] & r[47:40]);
      chk(sel(pin_pull_en), r[23:16]);
      chk(sel({4'h0, analog_sel}), r[15:8]);
      chk(sel(pin_hicur_en), r[63:56] & (p[0] ? 8'hf0 : 8'h00));
      rd(p);
      chk(got, r[7:0]);
    end
    @(posedge clock);
    rst_n <= 1'b0;
    ext_en <= 16'h0000;
    repeat (3) @(posedge clock);
    #1 chk(pin_oe, 16'h0000);
    chk(pin_pull_en, 16'hffff);
    @(posedge clock);
    rst_n <= 1'b1;
    for (i = 2; i < 7; i = i + 1) begin
      rd(i[2:0]);
      chk(got, 8'h00);
    end
    rd(`DPIO_OFS_A_VALUE);
    chk(got, 8'hff);
    wr(3'h7, 8'h5a);
    rd(3'h7);
    chk(got, 8'h00);
    wr(`DPIO_OFS_EDGE, 8'hff);
    rd(`DPIO_OFS_EDGE);
    chk(got, 8'h03);
    irq_step(16'h0000, 1'b0);
    wr(`DPIO_OFS_B_OPT, 8'hff);
    irq_step(16'h0100, 1'b1);
    irq_step(16'h0000, 1'b0);
    irq_step(16'h0001, 1'b0);
    wr(`DPIO_OFS_EDGE, 8'h00);
    irq_step(16'h0201, 1'b0);
    irq_step(16'h0001, 1'b1);
    wr(`DPIO_OFS_B_DIR, 8'h80);
    wr(`DPIO_OFS_B_OPT, 8'h7f);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clock);
      serial_out <= i[0];
      ext_val <= i[0] ? 16'h4001 : 16'h2001;
      repeat (3) @(posedge clock);
      #1 chk(pin_oe[15], !i[0]);
      chk({serial_clk_in, serial_data_in}, i[0] ? 2'h1 : 2'h2);
    end
    give_verdict;
  end
endmodule // dpio_top_tb
